/* File: rtl/drive_status_pkg.sv */
// package: drive status word, mode display and speed-deviation monitor
// assumes one 200 MHz control clock and a simple strobe register port
package drive_status_pkg;

    // clock and time
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned MS_PER_UNIT = 1;
    localparam int unsigned MS_CYCLES_DEF = MS_PER_UNIT * CLK_MHZ * 1000;
    localparam logic [15:0] MIN_TIME_MAX_MS = 16'h0032;

    // register port
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_MON_CTRL = 16'h2D50;
    localparam logic [15:0] IDX_THRESHOLD = 16'h2D51;
    localparam logic [15:0] IDX_MIN_TIME = 16'h2D52;
    localparam logic [15:0] IDX_RESPONSE = 16'h2D53;
    localparam logic [15:0] IDX_STATUS_WORD = 16'h2D60;
    localparam logic [15:0] IDX_VEL_SETPOINT = 16'h6043;
    localparam logic [15:0] IDX_SPEED_ACTUAL = 16'h6044;
    localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;
    localparam logic [15:0] IDX_VEL_ACTUAL = 16'h606C;

    // reset values and tolerance maximum
    localparam logic [31:0] THRESHOLD_RST = 32'h0000_0032;
    localparam logic [31:0] THRESHOLD_MAX = 32'h7FFF_FFFF;
    localparam logic [15:0] MIN_TIME_RST = 16'h0000;
    localparam logic [7:0] RESPONSE_RST = 8'h01;

    // monitor control fields
    localparam int CTRL_CLR_FAULT = 0;
    localparam int CTRL_CLR_WARN = 1;

    // status word bit positions
    localparam int SW_READY = 0;
    localparam int SW_ON = 1;
    localparam int SW_OP_EN = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_VOLTAGE = 4;
    localparam int SW_QSTOP_N = 5;
    localparam int SW_INHIBIT = 6;
    localparam int SW_WARN = 7;
    localparam int SW_PDO_OFF = 8;
    localparam int SW_REMOTE = 9;
    localparam int SW_TARGET = 10;
    localparam int SW_LIMIT = 11;
    localparam int SW_MODE_ACT = 12;
    localparam int SW_FOLLOW = 13;
    localparam int SW_BRAKE = 14;
    localparam int SW_SAFE_OFF_N = 15;

    // operating mode codes
    localparam logic signed [7:0] MODE_TEST = -8'sd10;
    localparam logic signed [7:0] MODE_MAKER_SPEED = -8'sd2;
    localparam logic signed [7:0] MODE_NONE = 8'sh00;
    localparam logic signed [7:0] MODE_CSP = 8'sh08;
    localparam logic signed [7:0] MODE_CSV = 8'sh09;
    localparam logic signed [7:0] MODE_CST = 8'sh0A;

    typedef enum logic [7:0] {
        RESP_NONE = 8'h00,
        RESP_FAULT = 8'h01,
        RESP_WARN = 8'h02
    } speed_response_t;

    // drive condition levels gathered by the surrounding control logic
    typedef struct packed {
        logic ready_to_switch_on;
        logic switched_on;
        logic operation_enabled;
        logic fault_active;
        logic warning_active;
        logic dc_link_ready;
        logic quick_stop_active;
        logic switch_on_inhibited;
        logic rpdo_deactivated;
        logic network_ready;
        logic in_target_window;
        logic setpoint_limited;
        logic test_mode;
        logic following_error;
        logic brake_released;
        logic safety_disabled;
        logic speed_ctrl_used;
    } drive_flags_t;

endpackage

/* File: rtl/deviation_timer.sv */
// persistence timer for the speed deviation against its tolerance
// assumes threshold and minimum time are stable registers of the caller
`timescale 1ns/10ps
module deviation_timer
    import drive_status_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic signed [31:0] deviation,
    input wire logic [31:0] threshold,
    input wire logic [15:0] min_time_ms,
    output logic expired
);
    logic [32:0] magnitude;
    logic over;
    logic [31:0] pre_q;
    logic [15:0] ms_q;

    // 33 bits so the most negative deviation does not wrap
    assign magnitude = deviation[31] ? 33'(-{deviation[31], deviation})
                                     : {1'b0, deviation};
    assign over = enable && (magnitude > {1'b0, threshold});

    // zero minimum time fires in the first exceeding cycle
    assign expired = over && (ms_q >= min_time_ms);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
        end
        else if (!over)
        begin
            pre_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
        end
        else if (ms_q < min_time_ms)
        begin
            if (pre_q == 32'(MS_CYCLES - 1))
            begin
                pre_q <= 32'h0000_0000;
                ms_q <= ms_q + 16'h0001;
            end
            else
            begin
                pre_q <= pre_q + 32'h0000_0001;
            end
        end
    end
endmodule

/* File: rtl/drive_status_monitor.sv */
// top: profile status word, mode and velocity displays, speed monitor
// assumes drive levels synchronous to mclk and a strobe register port
// Contract
// - bit 3 shows active fault
// - bit 4 shows DC link ready
// - bit 5 low during quick stop
// - bit 6 shows switch-on inhibited
// - bit 8 shows cyclic receive data off
// - bit 9 shows network commands accepted
// - bit 9 clear in maker speed mode
// - bit 10 shows position inside window
// - bit 11 shows setpoint being limited
// - bit 12 enabled and not test mode
// - bit 13 shows following error
// - bit 14 shows brake released
// - bit 15 low when safety disabled drive
// - signed mode display, test is minus ten
// - velocity setpoint readable in rpm
// - actual velocity readable in rpm
// - monitor speed-controller input, speed modes only
// - respond only after excess persists minimum time
// - tolerance 1 to 2147483647, default 50
// - minimum time 0 to 50 ms, default 0
// - response 0 none, 1 fault, 2 warning
// - bits 0..2 ready, on, operation enabled
// - mode codes 8, 9, 10 cyclic modes
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module drive_status_monitor
    import drive_status_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire drive_flags_t flags,
    input wire logic signed [7:0] mode_select,
    input wire logic signed [7:0] mode_active,
    input wire logic signed [31:0] vel_setpoint,
    input wire logic signed [31:0] vel_actual,
    input wire logic signed [31:0] speed_deviation,
    output logic [15:0] status_word,
    output logic signed [7:0] mode_display,
    output logic fault_to_profile_state,
    output logic speed_warning
);
    logic [31:0] threshold_q;
    logic [15:0] min_time_q;
    speed_response_t response_q;
    logic fault_q;
    logic warn_q;
    logic [15:0] status_q;
    logic signed [7:0] mode_q;
    logic signed [31:0] vel_set_q;
    logic signed [31:0] speed_act_q;
    logic signed [31:0] vel_act_q;
    logic [DATA_W-1:0] rdata_q;
    logic expired;
    logic fault_set;
    logic warn_set;
    logic clr_fault;
    logic clr_warn;
    logic wr_ctrl;
    logic [15:0] idx;
    logic [DATA_W-1:0] rdata_d;
    logic fault_d;
    logic warn_d;
    logic addr_mapped;
    logic wr_threshold;
    logic wr_min_time;
    logic wr_response;

    // word addresses only; the two low bits are ignored
    assign idx = reg_addr[17:2];
    // set top bits would alias real registers, so such accesses are unmapped
    assign addr_mapped = (reg_addr[ADDR_W-1:18] == 2'b00);
    assign wr_ctrl = reg_wr && addr_mapped && (idx == IDX_MON_CTRL);
    assign wr_threshold = reg_wr && addr_mapped && (idx == IDX_THRESHOLD);
    assign wr_min_time = reg_wr && addr_mapped && (idx == IDX_MIN_TIME);
    assign wr_response = reg_wr && addr_mapped && (idx == IDX_RESPONSE);
    assign clr_fault = wr_ctrl && reg_wdata[CTRL_CLR_FAULT];
    assign clr_warn = wr_ctrl && reg_wdata[CTRL_CLR_WARN];

    deviation_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(flags.speed_ctrl_used),
        .deviation(speed_deviation),
        .threshold(threshold_q),
        .min_time_ms(min_time_q),
        .expired(expired)
    );

    assign fault_set = expired && (response_q == RESP_FAULT);
    assign warn_set = expired && (response_q == RESP_WARN);

    // next sticky values, so the status word follows a clear without lag
    always_comb
    begin
        fault_d = fault_q;
        if (clr_fault)
        begin
            fault_d = 1'b0;
        end
        if (fault_set)
        begin
            fault_d = 1'b1;
        end
    end

    always_comb
    begin
        warn_d = warn_q;
        if (clr_warn)
        begin
            warn_d = 1'b0;
        end
        if (warn_set)
        begin
            warn_d = 1'b1;
        end
    end

    // tolerance: out-of-range writes are dropped, value kept
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            threshold_q <= THRESHOLD_RST;
        end
        else if (wr_threshold)
        begin
            if ((reg_wdata != 32'h0000_0000) && (reg_wdata <= THRESHOLD_MAX))
            begin
                threshold_q <= reg_wdata;
            end
        end
    end

    // minimum persistence time in ms
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            min_time_q <= MIN_TIME_RST;
        end
        else if (wr_min_time)
        begin
            if ((reg_wdata[31:16] == 16'h0000) && (reg_wdata[15:0] <= MIN_TIME_MAX_MS))
            begin
                min_time_q <= reg_wdata[15:0];
            end
        end
    end

    // response selector; undefined codes are ignored
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            response_q <= speed_response_t'(RESPONSE_RST);
        end
        else if (wr_response)
        begin
            case (reg_wdata)
                32'(RESP_NONE): response_q <= RESP_NONE;
                32'(RESP_FAULT): response_q <= RESP_FAULT;
                32'(RESP_WARN): response_q <= RESP_WARN;
                default: response_q <= response_q;
            endcase
        end
    end

    // sticky fault; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_q <= 1'b0;
        end
        else if (fault_set)
        begin
            fault_q <= 1'b1;
        end
        else if (clr_fault)
        begin
            fault_q <= 1'b0;
        end
    end

    // sticky warning, same set-over-clear policy
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warn_q <= 1'b0;
        end
        else if (warn_set)
        begin
            warn_q <= 1'b1;
        end
        else if (clr_warn)
        begin
            warn_q <= 1'b0;
        end
    end

    // status word, refreshed every cycle from the drive levels
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q <= 16'h0000;
        end
        else
        begin
            status_q[SW_READY] <= flags.ready_to_switch_on;
            status_q[SW_ON] <= flags.switched_on;
            status_q[SW_OP_EN] <= flags.operation_enabled;
            // next flag value: a new speed fault shows at once, a clear too
            status_q[SW_FAULT] <= flags.fault_active | fault_d;
            status_q[SW_VOLTAGE] <= flags.dc_link_ready;
            status_q[SW_QSTOP_N] <= ~flags.quick_stop_active;
            status_q[SW_INHIBIT] <= flags.switch_on_inhibited;
            status_q[SW_WARN] <= flags.warning_active | warn_d;
            status_q[SW_PDO_OFF] <= flags.rpdo_deactivated;
            status_q[SW_REMOTE] <= flags.network_ready && (mode_select != MODE_MAKER_SPEED);
            status_q[SW_TARGET] <= flags.in_target_window;
            status_q[SW_LIMIT] <= flags.setpoint_limited;
            status_q[SW_MODE_ACT] <= flags.operation_enabled & ~flags.test_mode;
            status_q[SW_FOLLOW] <= flags.following_error;
            status_q[SW_BRAKE] <= flags.brake_released;
            status_q[SW_SAFE_OFF_N] <= ~flags.safety_disabled;
        end
    end

    // mode display; test mode overrides the mode in effect
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_NONE;
        end
        else if (flags.test_mode)
        begin
            mode_q <= MODE_TEST;
        end
        else
        begin
            mode_q <= mode_active;
        end
    end

    // velocity setpoint display, sampled each cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vel_set_q <= 32'sh0000_0000;
        end
        else
        begin
            vel_set_q <= vel_setpoint;
        end
    end

    // both actual displays show the same measured value
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speed_act_q <= 32'sh0000_0000;
        end
        else
        begin
            speed_act_q <= vel_actual;
        end
    end

    // actual velocity display
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vel_act_q <= 32'sh0000_0000;
        end
        else
        begin
            vel_act_q <= vel_actual;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (idx)
            IDX_MON_CTRL: rdata_d = {30'h0000_0000, warn_q, fault_q};
            IDX_THRESHOLD: rdata_d = threshold_q;
            IDX_MIN_TIME: rdata_d = {16'h0000, min_time_q};
            IDX_RESPONSE: rdata_d = {24'h00_0000, response_q};
            IDX_STATUS_WORD: rdata_d = {16'h0000, status_q};
            IDX_VEL_SETPOINT: rdata_d = vel_set_q;
            IDX_SPEED_ACTUAL: rdata_d = speed_act_q;
            IDX_MODE_DISPLAY: rdata_d = {{24{mode_q[7]}}, mode_q};
            IDX_VEL_ACTUAL: rdata_d = vel_act_q;
            default: rdata_d = 32'h0000_0000;
        endcase
        if (!addr_mapped)
        begin
            rdata_d = 32'h0000_0000;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (reg_rd)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign status_word = status_q;
    assign mode_display = mode_q;
    assign fault_to_profile_state = fault_q;
    assign speed_warning = warn_q;
endmodule

/* File: verification/fieldbus_master.sv */
// fieldbus master model: acyclic reads and writes of drive objects
// assumes the strobe register port; read data stand one cycle later
`timescale 1ns/10ps
module fieldbus_master
    import drive_status_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] reg_rdata,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial
    begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // idle address and data inverted so stale values never look valid
    task automatic wr(input logic [15:0] idx, input logic [31:0] w);
        @(posedge mclk);
        reg_addr <= {2'b00, idx, 2'b00};
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] r);
        @(posedge mclk);
        reg_addr <= {2'b00, idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~reg_addr;
        #1;
        r = reg_rdata;
    endtask
endmodule

/* File: verification/drive_status_monitor_monitor.sv */
// checker: status word, mode display and speed flags at the top ports
// assumes binding into drive_status_monitor, one clock domain
`timescale 1ns/10ps
module drive_status_checker
    import drive_status_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire drive_flags_t flags,
    input wire logic signed [7:0] mode_select,
    input wire logic signed [7:0] mode_active,
    input wire logic [15:0] status_word,
    input wire logic signed [7:0] mode_display,
    input wire logic fault_to_profile_state,
    input wire logic speed_warning
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // first edge after release still sees reset-time outputs
    sequence s_live;
        $past(rst_n);
    endsequence
    sequence s_flag_rise;
        $rose(fault_to_profile_state) || $rose(speed_warning);
    endsequence

    property p_levels;
        s_live |-> {status_word[14:13], status_word[11:10], status_word[8], status_word[6],
            status_word[4], status_word[2:0]} == $past({flags.brake_released,
            flags.following_error, flags.setpoint_limited, flags.in_target_window,
            flags.rpdo_deactivated, flags.switch_on_inhibited, flags.dc_link_ready,
            flags.operation_enabled, flags.switched_on, flags.ready_to_switch_on});
    endproperty
    a_levels: assert property (p_levels) else $error("level bits");
    property p_fault;
        s_live |-> status_word[3] == ($past(flags.fault_active) | fault_to_profile_state);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit");
    property p_qstop;
        s_live |-> status_word[5] == !$past(flags.quick_stop_active);
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop bit");
    property p_remote;
        s_live |-> status_word[9] == ($past(flags.network_ready) && $past(mode_select) != -8'sd2);
    endproperty
    a_remote: assert property (p_remote) else $error("remote bit");
    property p_opmode;
        s_live |-> status_word[12] == $past(flags.operation_enabled && !flags.test_mode);
    endproperty
    a_opmode: assert property (p_opmode) else $error("mode active bit");
    property p_safe;
        s_live |-> status_word[15] == !$past(flags.safety_disabled);
    endproperty
    a_safe: assert property (p_safe) else $error("safety bit");
    property p_mode;
        s_live |-> mode_display == ($past(flags.test_mode) ? MODE_TEST : $past(mode_active));
    endproperty
    a_mode: assert property (p_mode) else $error("mode display");
    property p_gate;
        s_flag_rise |-> $past(flags.speed_ctrl_used);
    endproperty
    a_gate: assert property (p_gate) else $error("monitor outside speed mode");
endmodule

bind drive_status_monitor drive_status_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk, .rst_n,
    .flags, .mode_select, .mode_active, .status_word, .mode_display,
    .fault_to_profile_state, .speed_warning);

/* File: verification/testbench.sv */
// bench: status word, displays and speed monitor through the register port
// assumes fieldbus_master beside the design, mclk 200 MHz
`timescale 1ns/10ps
module testbench
    import drive_status_pkg::*;
;
    logic mclk, rst_n, reg_wr, reg_rd, fault_to_profile_state, speed_warning;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] status_word;
    drive_flags_t flags;
    logic signed [7:0] mode_select, mode_active, mode_display;
    logic signed [31:0] vel_setpoint, vel_actual, speed_deviation;
    int error_cnt = 0;
    int checks = 0;

    // short ms keeps the persistence test brief
    drive_status_monitor #(.MS_CYCLES(4)) dut (.mclk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .flags, .mode_select, .mode_active, .vel_setpoint,
        .vel_actual, .speed_deviation, .status_word, .mode_display,
        .fault_to_profile_state, .speed_warning);
    fieldbus_master fm (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic dev(input logic [31:0] v, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            speed_deviation <= v;
        end
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        fm.rd(idx, d);
        chk(d, exp);
    endtask

    task automatic wrd(input logic [15:0] idx, input logic [31:0] w, input logic [31:0] exp);
        fm.wr(idx, w);
        rdc(idx, exp);
    endtask

    function automatic logic [15:0] exp_sw(input drive_flags_t f, input logic maker);
        exp_sw = {!f.safety_disabled, f.brake_released, f.following_error,
            f.operation_enabled && !f.test_mode, f.setpoint_limited, f.in_target_window,
            f.network_ready && !maker, f.rpdo_deactivated, f.warning_active,
            f.switch_on_inhibited, !f.quick_stop_active, f.dc_link_ready, f.fault_active,
            f.operation_enabled, f.switched_on, f.ready_to_switch_on};
    endfunction

    task automatic t_regs();
        rdc(IDX_THRESHOLD, 32'h0000_0032);
        rdc(IDX_MIN_TIME, 32'h0000_0000);
        rdc(IDX_RESPONSE, 32'h0000_0001);
        wrd(IDX_THRESHOLD, 32'h0000_0000, 32'h0000_0032);
        wrd(IDX_THRESHOLD, 32'h8000_0000, 32'h0000_0032);
        wrd(IDX_THRESHOLD, 32'h7FFF_FFFF, 32'h7FFF_FFFF);
        wrd(IDX_THRESHOLD, 32'h0000_0001, 32'h0000_0001);
        wrd(IDX_MIN_TIME, 32'h0000_0033, 32'h0000_0000);
        wrd(IDX_MIN_TIME, 32'h0000_0032, 32'h0000_0032);
        wrd(IDX_RESPONSE, 32'h0000_0003, 32'h0000_0001);
        rdc(16'h1234, 32'h0000_0000);
        wrd(IDX_THRESHOLD, 32'h0000_0032, 32'h0000_0032);
        wrd(IDX_MIN_TIME, 32'h0000_0000, 32'h0000_0000);
    endtask

    task automatic t_status();
        for (int i = 0; i < 17; i++)
        begin
            @(posedge mclk);
            flags <= drive_flags_t'(17'h1 << i);
            settle(1);
            chk({16'h0, status_word}, {16'h0, exp_sw(flags, 1'b0)});
        end
        @(posedge mclk);
        flags <= drive_flags_t'(17'h0_4090);
        mode_select <= 8'hFE;
        settle(1);
        rdc(IDX_STATUS_WORD, {16'h0, exp_sw(flags, 1'b1)});
        @(posedge mclk);
        mode_select <= 8'h00;
    endtask

    task automatic t_modes();
        logic [7:0] codes [6] = '{8'hF6, 8'hFE, 8'h00, 8'h08, 8'h09, 8'h0A};
        rdc(IDX_MODE_DISPLAY, 32'hFFFF_FFF6);
        @(posedge mclk);
        flags <= '0;
        foreach (codes[i])
        begin
            @(posedge mclk);
            mode_active <= codes[i];
            settle(1);
            rdc(IDX_MODE_DISPLAY, {{24{codes[i][7]}}, codes[i]});
        end
        @(posedge mclk);
        vel_setpoint <= 32'hFFFF_FF38;
        vel_actual <= 32'h0000_04D2;
        settle(1);
        rdc(IDX_VEL_SETPOINT, 32'hFFFF_FF38);
        rdc(IDX_SPEED_ACTUAL, 32'h0000_04D2);
        rdc(IDX_VEL_ACTUAL, 32'h0000_04D2);
    endtask

    task automatic fire(input logic [31:0] r, input logic [31:0] v, input logic [1:0] fw);
        fm.wr(IDX_RESPONSE, r);
        dev(v, 1);
        settle(1);
        chk({30'h0, fault_to_profile_state, speed_warning}, {30'h0, fw});
        chk({30'h0, status_word[3], status_word[7]}, {30'h0, fw});
        rdc(IDX_MON_CTRL, {30'h0, fw[0], fw[1]});
        dev(32'h0, 1);
        fm.wr(IDX_MON_CTRL, 32'h0000_0003);
    endtask

    task automatic t_monitor();
        @(posedge mclk);
        flags <= drive_flags_t'(17'h1);
        fire(32'h1, 32'h32, 2'b00);
        fire(32'h1, 32'h33, 2'b10);
        fire(32'h1, 32'hFFFF_FFCD, 2'b10);
        fire(32'h2, 32'h33, 2'b01);
        fire(32'h0, 32'h33, 2'b00);
        fm.wr(IDX_MIN_TIME, 32'h1);
        fm.wr(IDX_RESPONSE, 32'h1);
        dev(32'h33, 3);
        dev(32'h0, 1);
        dev(32'h33, 3);
        settle(1);
        chk({31'h0, fault_to_profile_state}, 32'h0);
        dev(32'h33, 2);
        settle(1);
        chk({31'h0, fault_to_profile_state}, 32'h1);
        dev(32'h0, 1);
        flags <= '0;
        fm.wr(IDX_MON_CTRL, 32'h0000_0003);
        fm.wr(IDX_MIN_TIME, 32'h0000_0000);
        fire(32'h1, 32'h3E8, 2'b00);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        flags = '0;
        mode_select = '0;
        mode_active = '0;
        vel_setpoint = '0;
        vel_actual = '0;
        speed_deviation = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_status();
        t_modes();
        t_monitor();
        test_done();
    end
endmodule
